// File: core/dswp_consts.vh
`ifndef DSWP_CONSTS_VH
`define DSWP_CONSTS_VH
// three-wire frame and byte geometry
`define DSWP_FRAME_BITS   24
`define DSWP_BYTE_BITS    8
`define DSWP_BIT_LAST     3'h7
`define DSWP_BIT_ACK      4'h8
// byte positions inside a frame or transaction
`define DSWP_IDX_ID       2'h0
`define DSWP_IDX_REG      2'h1
`define DSWP_IDX_DATA     2'h2
// target id: two fixed top bits, then five pin bits
`define DSWP_ID_FIXED     2'h1
`define DSWP_DIR_WRITE    1'h0
// last register before wrap-around
`define DSWP_ADDR_WRAP    8'h15
`define DSWP_ADDR_FIRST   8'h00
// write buffer
`define DSWP_FIFO_DEPTH   4
`define DSWP_FIFO_AW      2
`define DSWP_WORD_W       16
`endif

// File: core/dswp_top.v
`timescale 1ns/1ps
// Functional notes
// - three-wire frame is 24 bits while enable high, data sampled on clock rise
// - 23 or fewer clock rises in one enable-high period write nothing
// - with 25 or more clocks, address advances after each whole byte
// - three-wire bytes are target id, register address, then data
// - trailing partial byte of a three-wire frame is dropped
// - after register 15h the next byte goes to register 00h
// - both two-wire lines rest high when idle; nobody pulls them low
// - data fall with clock high is start; data rise with clock high is stop
// - after start, any number of 8-bit bytes follow back to back
// - receiver pulls data low right after the eighth clock fall
// - receiver releases data at the ninth clock fall
// - first two-wire byte is 7-bit id msb first plus low direction bit
// - two-wire side accepts writes only, never drives read data
// - id top bits are 0 then 1, then the five select pins
`include "dswp_consts.vh"

module dswp_fifo #(
  parameter W  = 16,
  parameter D  = 4,
  parameter AW = 2
) (
  input  wire          sys_clk,
  input  wire          rst,
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW-1:0] wptr_ff;
  reg  [AW-1:0] rptr_ff;
  reg  [AW:0]   count_ff;
  wire          do_push = in_valid & in_ready;
  wire          do_pop  = out_valid & out_ready;

  assign in_ready  = (count_ff != D[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rptr_ff];

  always @(posedge sys_clk) begin
    if (do_push) begin
      mem[wptr_ff] <= in_data;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wptr_ff  <= {AW{1'b0}};
      rptr_ff  <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wptr_ff <= (wptr_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_ff + 1'b1;
      end
      if (do_pop) begin
        rptr_ff <= (rptr_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_ff + 1'b1;
      end
      count_ff <= count_ff + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end
endmodule // dswp_fifo

module dswp_top #(
  parameter FIFO_DEPTH = `DSWP_FIFO_DEPTH,
  parameter FIFO_AW    = `DSWP_FIFO_AW
) (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       if_select_i2c,
  input  wire       frame_enable_in,
  input  wire       serial_clk_in,
  input  wire       serial_data_in,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out_ff,
  output reg        sda_oe_ff,
  input  wire       addr_select_pin_4,
  input  wire       addr_select_pin_3,
  input  wire       addr_select_pin_2,
  input  wire       addr_select_pin_1,
  input  wire       addr_select_pin_0,
  output reg        reg_wr_valid_ff,
  input  wire       reg_wr_ready,
  output reg  [7:0] reg_wr_addr_ff,
  output reg  [7:0] reg_wr_data_ff,
  output reg        wr_overflow_ff
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_RX   = 4'h2;
  localparam [3:0] ST_ACK  = 4'h4;
  localparam [3:0] ST_SKIP = 4'h8;

  // every pin input passes two flops before use
  // reset to each line's idle level, so no false edge follows reset
  localparam [10:0] SYNC_IDLE = 11'h060;
  reg  [10:0] sync1_ff;
  reg  [10:0] sync2_ff;
  wire [10:0] pins_raw;
  assign pins_raw = {if_select_i2c, frame_enable_in, serial_clk_in, serial_data_in,
                     scl_in, sda_in, addr_select_pin_4, addr_select_pin_3,
                     addr_select_pin_2, addr_select_pin_1, addr_select_pin_0};

  genvar gi;
  generate
    for (gi = 0; gi < 11; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          sync1_ff[gi] <= SYNC_IDLE[gi];
          sync2_ff[gi] <= SYNC_IDLE[gi];
        end else begin
          sync1_ff[gi] <= pins_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate
  reg        tw_clk_prev_ff;
  reg        scl_prev_ff;
  reg        sda_prev_ff;

  wire       mode_i2c = sync2_ff[10];
  wire       tw_en    = sync2_ff[9];
  wire       tw_clk   = sync2_ff[8];
  wire       tw_dat   = sync2_ff[7];
  wire       scl      = sync2_ff[6];
  wire       sda      = sync2_ff[5];
  wire [6:0] own_id   = {`DSWP_ID_FIXED, sync2_ff[4:0]};

  wire tw_rise = tw_clk & ~tw_clk_prev_ff;
  wire scl_rise = scl & ~scl_prev_ff;
  wire scl_fall = ~scl & scl_prev_ff;
  wire i2c_start = scl & scl_prev_ff & sda_prev_ff & ~sda;
  wire i2c_stop  = scl & scl_prev_ff & ~sda_prev_ff & sda;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tw_clk_prev_ff <= 1'b0;
      scl_prev_ff    <= 1'b1;
      sda_prev_ff    <= 1'b1;
    end else begin
      tw_clk_prev_ff <= tw_clk;
      scl_prev_ff    <= scl;
      sda_prev_ff    <= sda;
    end
  end

  function [7:0] next_addr(input [7:0] a);
    next_addr = (a == `DSWP_ADDR_WRAP) ? `DSWP_ADDR_FIRST : a + 8'h01;
  endfunction

  // fifo between both engines and the register port
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire        fifo_pop = fifo_out_valid & (~reg_wr_valid_ff | reg_wr_ready);
  reg         tw_push_ff;
  reg  [15:0] tw_word_ff;
  reg         ic_push_ff;
  reg  [15:0] ic_word_ff;

  dswp_fifo #(
    .W  (`DSWP_WORD_W),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (tw_push_ff | ic_push_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (ic_push_ff ? ic_word_ff : tw_word_ff),
    .out_valid (fifo_out_valid),
    .out_ready (~reg_wr_valid_ff | reg_wr_ready),
    .out_data  (fifo_out_data)
  );

  // three-wire engine
  reg  [7:0] tw_shift_ff;
  reg  [2:0] tw_bit_ff;
  reg  [1:0] tw_byte_ff;
  reg        tw_match_ff;
  reg  [7:0] tw_addr_ff;
  wire [7:0] tw_byte = {tw_shift_ff[6:0], tw_dat};
  wire       tw_take = tw_rise & tw_en & ~mode_i2c;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tw_shift_ff <= 8'h00;
      tw_bit_ff   <= 3'h0;
      tw_byte_ff  <= 2'h0;
      tw_match_ff <= 1'b0;
      tw_addr_ff  <= 8'h00;
      tw_push_ff  <= 1'b0;
      tw_word_ff  <= 16'h0000;
    end else begin
      tw_push_ff <= 1'b0;
      if (!tw_en || mode_i2c) begin
        // a partial byte dies with the frame
        tw_bit_ff   <= 3'h0;
        tw_byte_ff  <= 2'h0;
        tw_match_ff <= 1'b0;
      end else if (tw_take) begin
        tw_shift_ff <= tw_byte;
        tw_bit_ff   <= tw_bit_ff + 3'h1;
        if (tw_bit_ff == `DSWP_BIT_LAST) begin
          case (tw_byte_ff)
            `DSWP_IDX_ID: begin
              tw_match_ff <= (tw_byte[7:1] == own_id);
              tw_byte_ff  <= `DSWP_IDX_REG;
            end
            `DSWP_IDX_REG: begin
              tw_addr_ff <= tw_byte;
              tw_byte_ff <= `DSWP_IDX_DATA;
            end
            default: begin
              // third byte ends on the 24th rise, so short frames never push
              tw_push_ff <= tw_match_ff;
              tw_word_ff <= {tw_addr_ff, tw_byte};
              tw_addr_ff <= next_addr(tw_addr_ff);
            end
          endcase
        end
      end
    end
  end

  // two-wire engine
  reg  [3:0] ic_st_ff;
  reg  [3:0] nxt_ic_st;
  reg  [7:0] ic_shift_ff;
  reg  [7:0] nxt_ic_shift;
  reg  [3:0] ic_bit_ff;
  reg  [3:0] nxt_ic_bit;
  reg  [1:0] ic_byte_ff;
  reg  [1:0] nxt_ic_byte;
  reg  [7:0] ic_addr_ff;
  reg  [7:0] nxt_ic_addr;
  reg        nxt_sda_oe;
  reg        nxt_ic_push;
  reg        ic_ack;

  always @* begin
    nxt_ic_st    = ic_st_ff;
    nxt_ic_shift = ic_shift_ff;
    nxt_ic_bit   = ic_bit_ff;
    nxt_ic_byte  = ic_byte_ff;
    nxt_ic_addr  = ic_addr_ff;
    nxt_sda_oe   = sda_oe_ff;
    nxt_ic_push  = 1'b0;
    ic_ack       = 1'b0;
    if (!mode_i2c) begin
      nxt_ic_st  = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (i2c_stop) begin
      nxt_ic_st  = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (i2c_start) begin
      nxt_ic_st   = ST_RX;
      nxt_ic_bit  = 4'h0;
      nxt_ic_byte = `DSWP_IDX_ID;
      nxt_sda_oe  = 1'b0;
    end else begin
      case (ic_st_ff)
        ST_IDLE, ST_SKIP: begin
          nxt_sda_oe = 1'b0;
        end
        ST_RX: begin
          if (scl_rise && ic_bit_ff != `DSWP_BIT_ACK) begin
            nxt_ic_shift = {ic_shift_ff[6:0], sda};
            nxt_ic_bit   = ic_bit_ff + 4'h1;
          end else if (scl_fall && ic_bit_ff == `DSWP_BIT_ACK) begin
            case (ic_byte_ff)
              `DSWP_IDX_ID: begin
                // read requests are never answered
                ic_ack = (ic_shift_ff[7:1] == own_id) &&
                         (ic_shift_ff[0] == `DSWP_DIR_WRITE);
              end
              `DSWP_IDX_REG: begin
                ic_ack      = 1'b1;
                nxt_ic_addr = ic_shift_ff;
              end
              default: begin
                // full buffer: no ack, so the host sees the stall
                ic_ack      = fifo_in_ready;
                nxt_ic_push = fifo_in_ready;
              end
            endcase
            if (ic_ack) begin
              nxt_sda_oe = 1'b1;
              nxt_ic_st  = ST_ACK;
            end else begin
              nxt_ic_st = ST_SKIP;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt_sda_oe = 1'b0;
            nxt_ic_st  = ST_RX;
            nxt_ic_bit = 4'h0;
            if (ic_byte_ff != `DSWP_IDX_DATA) begin
              nxt_ic_byte = ic_byte_ff + 2'h1;
            end
          end
        end
        default: begin
          nxt_ic_st  = ST_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ic_st_ff    <= ST_IDLE;
      ic_shift_ff <= 8'h00;
      ic_bit_ff   <= 4'h0;
      ic_byte_ff  <= 2'h0;
      ic_addr_ff  <= 8'h00;
      sda_oe_ff   <= 1'b0;
      sda_out_ff  <= 1'b0;
      ic_push_ff  <= 1'b0;
      ic_word_ff  <= 16'h0000;
    end else begin
      ic_st_ff    <= nxt_ic_st;
      ic_shift_ff <= nxt_ic_shift;
      ic_bit_ff   <= nxt_ic_bit;
      ic_byte_ff  <= nxt_ic_byte;
      sda_oe_ff   <= nxt_sda_oe;
      sda_out_ff  <= 1'b0;
      ic_push_ff  <= nxt_ic_push;
      if (nxt_ic_push) begin
        ic_word_ff <= {ic_addr_ff, ic_shift_ff};
        ic_addr_ff <= next_addr(ic_addr_ff);
      end else begin
        ic_addr_ff <= nxt_ic_addr;
      end
    end
  end

  // registered write port, drained from the fifo
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_wr_valid_ff <= 1'b0;
      reg_wr_addr_ff  <= 8'h00;
      reg_wr_data_ff  <= 8'h00;
      wr_overflow_ff  <= 1'b0;
    end else begin
      if (fifo_pop) begin
        reg_wr_valid_ff <= 1'b1;
        reg_wr_addr_ff  <= fifo_out_data[15:8];
        reg_wr_data_ff  <= fifo_out_data[7:0];
      end else if (reg_wr_ready) begin
        reg_wr_valid_ff <= 1'b0;
      end
      // three-wire host cannot be stalled; a lost byte is flagged
      wr_overflow_ff <= tw_push_ff & ~fifo_in_ready;
    end
  end
endmodule // dswp_top

// File: tb/dswp_host.sv
`timescale 1ns/1ps
module dswp_host (
  input  wire logic sys_clk,
  input  wire logic sda_w,
  output logic      en,
  output logic      sck,
  output logic      sdo,
  output logic      scl,
  output logic      sda_m
);
  initial begin
    en = 1'b0;
    sck = 1'b0;
    sdo = 1'b0;
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic tw_bit(input logic d);
    sck <= 1'b0;
    hw(6);
    sdo <= d;
    hw(6);
    sck <= 1'b1;
    hw(13);
  endtask
  task automatic tw_frame(input logic [7:0] b[$], input int extra);
    en <= 1'b1;
    hw(20);
    foreach (b[i]) for (int k = 7; k >= 0; k--) tw_bit(b[i][k]);
    for (int k = 0; k < extra; k++) tw_bit(k[0]);
    sck <= 1'b0;
    hw(40);
    en <= 1'b0;
    // hold time over: data line no longer shows the last bit
    sdo <= ~sdo;
    hw(220);
  endtask
  task automatic i2_bit(input logic d);
    hw(10);
    sda_m <= d;
    hw(15);
    scl <= 1'b1;
    hw(25);
    scl <= 1'b0;
  endtask
  task automatic i2_xfer(input logic [7:0] b[$], output int acks);
    acks = 0;
    sda_m <= 1'b0;
    hw(25);
    scl <= 1'b0;
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k--) i2_bit(b[i][k]);
      hw(10);
      sda_m <= 1'b1;
      hw(20);
      scl <= 1'b1;
      hw(10);
      acks += int'(sda_w === 1'b0);
      hw(15);
      scl <= 1'b0;
    end
    hw(10);
    sda_m <= 1'b0;
    hw(15);
    scl <= 1'b1;
    hw(25);
    sda_m <= 1'b1;
    hw(100);
  endtask
endmodule // dswp_host

// File: tb/dswp_top_properties.sv
`timescale 1ns/1ps
module dswp_props (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       if_select_i2c,
  input wire logic       scl_in,
  input wire logic       sda_out_ff,
  input wire logic       sda_oe_ff,
  input wire logic       reg_wr_valid_ff,
  input wire logic       reg_wr_ready,
  input wire logic [7:0] reg_wr_addr_ff,
  input wire logic [7:0] reg_wr_data_ff,
  input wire logic       wr_overflow_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_ack_hold;
    sda_oe_ff [*8];
  endsequence
  sequence s_stall;
    reg_wr_valid_ff && !reg_wr_ready;
  endsequence
  chk_word_held: assert property (s_stall |=> reg_wr_valid_ff &&
    $stable(reg_wr_addr_ff) && $stable(reg_wr_data_ff)) else $error("stalled word changed");
  chk_ack_low: assert property (sda_oe_ff |-> !sda_out_ff)
    else $error("ack drive not low");
  chk_ack_span: assert property ($rose(sda_oe_ff) |-> s_ack_hold)
    else $error("ack too short");
  chk_ack_scl_low: assert property ($changed(sda_oe_ff) |-> !scl_in)
    else $error("ack moved while clock high");
  chk_ack_release: assert property ($fell(scl_in) && sda_oe_ff |-> ##[1:5] !sda_oe_ff)
    else $error("ack not released");
  chk_ack_mode: assert property (!if_select_i2c [*4] |-> !sda_oe_ff)
    else $error("ack in three-wire mode");
  chk_ovf_pulse: assert property (wr_overflow_ff |=> !wr_overflow_ff)
    else $error("overflow not a pulse");
  chk_ovf_full: assert property (wr_overflow_ff |-> reg_wr_valid_ff && !if_select_i2c)
    else $error("overflow without stall");
endmodule // dswp_props
bind dswp_top dswp_props i_dswp_props (.sys_clk(sys_clk), .rst(rst),
  .if_select_i2c(if_select_i2c), .scl_in(scl_in), .sda_out_ff(sda_out_ff),
  .sda_oe_ff(sda_oe_ff), .reg_wr_valid_ff(reg_wr_valid_ff), .reg_wr_ready(reg_wr_ready),
  .reg_wr_addr_ff(reg_wr_addr_ff), .reg_wr_data_ff(reg_wr_data_ff),
  .wr_overflow_ff(wr_overflow_ff));

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk;
  logic        rst;
  logic        if_select_i2c;
  logic [4:0]  pins;
  logic        reg_wr_ready;
  wire         frame_enable_in, serial_clk_in, serial_data_in, scl_in, sda_m, sda_in;
  wire         sda_out_ff, sda_oe_ff, reg_wr_valid_ff, wr_overflow_ff;
  wire  [7:0]  reg_wr_addr_ff, reg_wr_data_ff, idb;
  logic [15:0] wq[$];
  int          mismatches = 0, cmp_count = 0, ovf = 0, cyc = 0;
  assign sda_in = sda_m & ~(sda_oe_ff & ~sda_out_ff);
  assign idb = {2'b01, pins, 1'b0};
  dswp_top i_dswp_top (.sys_clk(sys_clk), .rst(rst), .if_select_i2c(if_select_i2c),
    .frame_enable_in(frame_enable_in), .serial_clk_in(serial_clk_in),
    .serial_data_in(serial_data_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff), .addr_select_pin_4(pins[4]),
    .addr_select_pin_3(pins[3]), .addr_select_pin_2(pins[2]), .addr_select_pin_1(pins[1]),
    .addr_select_pin_0(pins[0]), .reg_wr_valid_ff(reg_wr_valid_ff),
    .reg_wr_ready(reg_wr_ready), .reg_wr_addr_ff(reg_wr_addr_ff),
    .reg_wr_data_ff(reg_wr_data_ff), .wr_overflow_ff(wr_overflow_ff));
  dswp_host i_dswp_host (.sys_clk(sys_clk), .sda_w(sda_in), .en(frame_enable_in),
    .sck(serial_clk_in), .sdo(serial_data_in), .scl(scl_in), .sda_m(sda_m));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic fail(input string m);
    mismatches++;
    $display("FAIL %0t %s", $time, m);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (reg_wr_valid_ff === 1'b1 && reg_wr_ready === 1'b1)
      wq.push_back({reg_wr_addr_ff, reg_wr_data_ff});
    if (wr_overflow_ff === 1'b1) ovf++;
    if (cyc == 60000) begin
      fail("timeout");
      report_and_stop();
    end
  end
  task automatic exp_wr(input logic [7:0] a, input logic [7:0] d);
    cmp_count++;
    if (wq.size() == 0 || wq[0] !== {a, d}) fail("write word wrong or missing");
    if (wq.size() != 0) wq.delete(0);
  endtask
  task automatic exp_n(input int n);
    cmp_count++;
    if (wq.size() != n) fail("unexpected write count");
  endtask
  task automatic exp_ack(input int got, input int n);
    cmp_count++;
    if (got != n) fail("acknowledge count wrong");
  endtask
  task automatic t_tw_basic;
    i_dswp_host.tw_frame('{idb, 8'h05, 8'ha5}, 0);
    exp_wr(8'h05, 8'ha5);
    exp_n(0);
  endtask
  task automatic t_tw_reject;
    i_dswp_host.tw_frame('{idb, 8'h05}, 7);
    exp_n(0);
    i_dswp_host.tw_frame('{idb ^ 8'h04, 8'h05, 8'h11}, 0);
    exp_n(0);
  endtask
  task automatic t_tw_wrap;
    i_dswp_host.tw_frame('{idb, 8'h14, 8'h31, 8'h32, 8'h33}, 5);
    exp_wr(8'h14, 8'h31);
    exp_wr(8'h15, 8'h32);
    exp_wr(8'h00, 8'h33);
    exp_n(0);
  endtask
  task automatic t_fifo_full;
    reg_wr_ready <= 1'b0;
    ovf = 0;
    i_dswp_host.tw_frame('{idb, 8'h08, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76}, 0);
    cmp_count++;
    if (ovf == 0) fail("no overflow with sink stalled");
    reg_wr_ready <= 1'b1;
    repeat (20) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) exp_wr(8'h08 + 8'(i), 8'h70 + 8'(i));
    wq.delete();
  endtask
  task automatic t_i2_write(input logic [4:0] p);
    int a;
    pins <= p;
    repeat (5) @(posedge sys_clk);
    i_dswp_host.i2_xfer('{{2'b01, p, 1'b0}, 8'h15, 8'h41, 8'h42}, a);
    exp_ack(a, 4);
    exp_wr(8'h15, 8'h41);
    exp_wr(8'h00, 8'h42);
  endtask
  task automatic t_i2_refuse;
    int a;
    i_dswp_host.i2_xfer('{idb ^ 8'h40, 8'h02, 8'h51}, a);
    exp_ack(a, 0);
    i_dswp_host.i2_xfer('{idb | 8'h01, 8'h02}, a);
    exp_ack(a, 0);
    i_dswp_host.tw_frame('{idb, 8'h03, 8'h61}, 0);
    exp_n(0);
  endtask
  initial begin
    rst = 1'b1;
    if_select_i2c = 1'b0;
    pins = 5'h13;
    reg_wr_ready = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_tw_basic();
    t_tw_reject();
    t_tw_wrap();
    t_fifo_full();
    if_select_i2c <= 1'b1;
    repeat (5) @(posedge sys_clk);
    t_i2_write(5'h13);
    t_i2_write(5'h0c);
    t_i2_refuse();
    report_and_stop();
  end
endmodule // tb_top
